/* core/tdm_timing_map.svh */
// register offsets, field positions, reset values and counts of the tdm group timing block
// Summary of operation
// RULE1 - first input stream runs at every group rate
// RULE2 - second input stream ignored at 65.536 Mbps
// RULE3 - third, fourth inputs only at 8/16 Mbps
// RULE4 - first output stream at every output rate
// RULE5 - second output stream unused at 65.536 Mbps
// RULE6 - third, fourth outputs only at 8/16 Mbps
// RULE7 - unused output streams are held tristated
// RULE8 - per-group input and output data inversion
// RULE9 - timing source always supplies master clock
// RULE10 - master frequency taken from select pins
// RULE11 - select codes 00/01/10/11 = 8/16/32/65 MHz
// RULE12 - programmable active edge per input clock
// RULE13 - source supplies 8 kHz master frame pulse
// RULE14 - programmable frame pulse active level
// RULE15 - optional clock frequencies detected automatically
// RULE16 - each optional clock has own frame pulse
// RULE17 - group settings take effect at frame boundary
`ifndef TDM_TIMING_MAP_SVH
`define TDM_TIMING_MAP_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OFF_CLK_CTRL   12'h000
`define OFF_STATUS     12'h004
`define OFF_GRP_BASE   12'h100

// ----------------------------------------------------------------
// clock control fields: per source i, edge at 2i, level at 2i+1
// ----------------------------------------------------------------
`define CC_EDGE_FALL   0
`define CC_FP_LOW      1
`define CC_RESET       6'h00

// ----------------------------------------------------------------
// group control fields
// ----------------------------------------------------------------
`define GC_IN_RATE_LO  0
`define GC_IN_INV      2
`define GC_OUT_RATE_LO 4
`define GC_OUT_INV     6
`define GC_RESET       7'h00

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ST_SEL_LO      0
`define ST_DET1_LO     2
`define ST_DET2_LO     4
`define ST_DET_OK_LO   6

// ----------------------------------------------------------------
// detector: clock edges per 8 kHz frame, 1024 at 8.192 MHz
// ----------------------------------------------------------------
`define DET_T16        14'd1536
`define DET_T32        14'd3072
`define DET_T65        14'd6144

`endif

/* core/tdm_timing_pkg.sv */
// types shared by the tdm group timing block
package tdm_timing_pkg;

    // rate code, shared by group rates and the frequency select pins
    typedef enum logic [1:0] {
        RATE_8  = 2'b00,
        RATE_16 = 2'b01,
        RATE_32 = 2'b10,
        RATE_65 = 2'b11
    } rate_e;

    // optional clock detector states
    typedef enum logic [1:0] {
        DET_WAIT  = 2'b01,
        DET_COUNT = 2'b10
    } det_e;

    // one group's settings
    typedef struct packed {
        logic  out_inv;
        rate_e out_rate;
        logic  in_inv;
        rate_e in_rate;
    } grp_cfg_s;

    // apb request
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_s;

endpackage

/* core/tdm_stream_group_timing.sv */
// tdm stream group timing: rate and inversion per group of four, shared master framing and optional clock detection
`timescale 1ns/1ps
`include "tdm_timing_map.svh"

module tdm_stream_group_timing
    import tdm_timing_pkg::*;
#(
    parameter int NG = 32
) (
    // clock, reset, enable
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // timing pins
    input  wire logic              MASTER_BIT_CLOCK_IN,
    input  wire logic              MASTER_FRAME_PULSE_IN,
    input  wire logic [1:0]        OPTIONAL_BIT_CLOCKS_IN,
    input  wire logic [1:0]        OPTIONAL_FRAME_PULSES_IN,
    input  wire logic [1:0]        MASTER_FREQ_SELECT,
    // serial input pins
    input  wire logic [NG-1:0]     SERIAL_IN_FIRST_STREAMS,
    input  wire logic [NG-1:0]     SERIAL_IN_SECOND_STREAMS,
    input  wire logic [NG-1:0]     SERIAL_IN_THIRD_STREAMS,
    input  wire logic [NG-1:0]     SERIAL_IN_FOURTH_STREAMS,
    // serial output pins, enable low while driven
    output logic      [NG-1:0]     SERIAL_OUT_FIRST_STREAMS,
    output logic      [NG-1:0]     SERIAL_OUT_SECOND_STREAMS,
    output logic      [NG-1:0]     SERIAL_OUT_THIRD_STREAMS,
    output logic      [NG-1:0]     SERIAL_OUT_FOURTH_STREAMS,
    output logic      [NG-1:0][3:0] SERIAL_OUT_OE_N,
    // received bits towards the switch core, stream index 0..3 = first..fourth
    output logic      [NG-1:0][3:0] RX_DATA,
    output logic      [NG-1:0][3:0] RX_VALID,
    // bits to transmit, taken at each output bit boundary
    input  wire logic [NG-1:0][3:0] TX_DATA,
    output logic      [NG-1:0][3:0] TX_TAKEN,
    // current frame position in master clock edges
    output logic      [15:0]       FRAME_EDGE_COUNT,
    output logic                   FRAME_START
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NG-1:0][3:0]    in_s1;
        logic [NG-1:0][3:0]    in_s2;
        logic [2:0]            ck_s1;
        logic [2:0]            ck_s2;
        logic [2:0]            ck_d;
        logic [2:0]            fp_s1;
        logic [2:0]            fp_s2;
        logic [1:0]            sel_s1;
        logic [1:0]            sel_s2;
        logic [5:0]            clk_ctrl;
        grp_cfg_s [NG-1:0]     cfg_pend;
        grp_cfg_s [NG-1:0]     cfg_act;
        logic [15:0]           edge_cnt;
        logic                  frame;
        logic [NG-1:0][3:0]    rx_data;
        logic [NG-1:0][3:0]    rx_valid;
        logic [NG-1:0][3:0]    tx_bit;
        logic [NG-1:0][3:0]    tx_taken;
        logic [31:0]           prdata;
        det_e [1:0]            det_st;
        logic [1:0][13:0]      det_cnt;
        logic [1:0][1:0]       det_rate;
        logic [1:0]            det_ok;
    } state_s;

    state_s   st_reg;
    state_s   st_next;
    apb_req_s req;
    logic     grp_hit;
    logic     any_hit;
    logic [9:0] gidx;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // stream k of a group is in use at rate r
    function automatic logic stream_used(rate_e r, int k);
        if (k == 0) begin
            return 1'b1;
        end else if (k == 1) begin
            return r != RATE_65;
        end else begin
            return (r == RATE_8) || (r == RATE_16);
        end
    endfunction

    // active edge found from the synced level and the previous one
    function automatic logic act_edge(logic cur, logic prev, logic fall);
        return (cur != prev) && (cur == ~fall);
    endfunction

    // edges per data bit minus one; a rate above the clock samples every edge
    function automatic logic [2:0] bit_mask(logic [1:0] sel, rate_e r);
        logic [1:0] d;
        d = (sel > r) ? 2'(sel - r) : 2'd0;
        case (d)
            2'd0: bit_mask = 3'h0;
            2'd1: bit_mask = 3'h1;
            2'd2: bit_mask = 3'h3;
            default: bit_mask = 3'h7;
        endcase
    endfunction

    // frame length in edges to rate code
    function automatic logic [1:0] classify(logic [13:0] n);
        if (n >= `DET_T65) begin
            return 2'(RATE_65);
        end else if (n >= `DET_T32) begin
            return 2'(RATE_32);
        end else if (n >= `DET_T16) begin
            return 2'(RATE_16);
        end else begin
            return 2'(RATE_8);
        end
    endfunction

    // ----------------------------------------------------------------
    // apb decode, zero wait states
    // ----------------------------------------------------------------
    assign req  = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
    assign gidx = PADDR[11:2] - 10'(`OFF_GRP_BASE >> 2);

    always_comb begin
        grp_hit = (PADDR >= `OFF_GRP_BASE) && (gidx < 10'(NG)) && (PADDR[1:0] == 2'b00);
        if (PADDR == `OFF_CLK_CTRL) begin
            any_hit = 1'b1;
        end else if (PADDR == `OFF_STATUS) begin
            any_hit = 1'b1;
        end else begin
            any_hit = grp_hit;
        end
    end

    assign PREADY  = 1'b1;
    assign PSLVERR = req.sel && req.enable && !any_hit; // unmapped: error, reads zero

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] act;
        logic [2:0] fpa;
        logic [15:0] cnt_n;
        logic [1:0]  sel;
        logic [3:0]  in_v;
        grp_cfg_s    c;
        st_next = st_reg;
        act     = '0;
        fpa     = '0;
        in_v    = '0;
        c       = '0;

        // two-flop synchronisers on every timing and serial input pin
        for (int g = 0; g < NG; g++) begin
            st_next.in_s1[g] = {SERIAL_IN_FOURTH_STREAMS[g], SERIAL_IN_THIRD_STREAMS[g],
                                SERIAL_IN_SECOND_STREAMS[g], SERIAL_IN_FIRST_STREAMS[g]};
        end
        st_next.in_s2  = st_reg.in_s1;
        st_next.ck_s1  = {OPTIONAL_BIT_CLOCKS_IN, MASTER_BIT_CLOCK_IN};
        st_next.ck_s2  = st_reg.ck_s1;
        st_next.ck_d   = st_reg.ck_s2;
        st_next.fp_s1  = {OPTIONAL_FRAME_PULSES_IN, MASTER_FRAME_PULSE_IN};
        st_next.fp_s2  = st_reg.fp_s1;
        st_next.sel_s1 = MASTER_FREQ_SELECT;
        st_next.sel_s2 = st_reg.sel_s1;
        sel            = st_reg.sel_s2; // RULE10 RULE11

        // edge and level per source, all from the second flop onward
        for (int i = 0; i < 3; i++) begin
            act[i] = act_edge(st_reg.ck_s2[i], st_reg.ck_d[i], st_reg.clk_ctrl[2*i+`CC_EDGE_FALL]); // RULE12
            fpa[i] = st_reg.fp_s2[i] ^ st_reg.clk_ctrl[2*i+`CC_FP_LOW]; // RULE14
        end

        // master framing: a frame pulse seen at an active edge restarts the count
        st_next.frame    = 1'b0;
        st_next.rx_valid = '0;
        st_next.tx_taken = '0;
        cnt_n            = st_reg.edge_cnt;
        if (act[0]) begin
            if (fpa[0]) begin
                cnt_n            = 16'h0000;
                st_next.frame    = 1'b1;
                st_next.cfg_act  = st_reg.cfg_pend; // RULE17
            end else begin
                cnt_n = st_reg.edge_cnt + 16'h0001;
            end
            st_next.edge_cnt = cnt_n;
        end

        // per group bit boundaries; new settings are seen from the frame edge on
        for (int g = 0; g < NG; g++) begin
            c = st_next.cfg_act[g];
            if (act[0] && ((cnt_n[2:0] & bit_mask(sel, c.in_rate)) == 3'h0)) begin
                in_v = st_reg.in_s2[g] ^ {4{c.in_inv}}; // RULE8
                for (int k = 0; k < 4; k++) begin
                    if (stream_used(c.in_rate, k)) begin // RULE1 RULE2 RULE3
                        st_next.rx_data[g][k]  = in_v[k];
                        st_next.rx_valid[g][k] = 1'b1;
                    end else begin
                        st_next.rx_data[g][k]  = 1'b0;
                    end
                end
            end
            if (act[0] && ((cnt_n[2:0] & bit_mask(sel, c.out_rate)) == 3'h0)) begin
                for (int k = 0; k < 4; k++) begin
                    if (stream_used(c.out_rate, k)) begin // RULE4 RULE5 RULE6
                        st_next.tx_bit[g][k]   = TX_DATA[g][k] ^ c.out_inv; // RULE8
                        st_next.tx_taken[g][k] = 1'b1;
                    end else begin
                        st_next.tx_bit[g][k]   = 1'b0;
                    end
                end
            end
        end

        // optional clocks: count active edges between their own frame pulses
        for (int i = 0; i < 2; i++) begin
            if (act[i+1]) begin
                if (fpa[i+1]) begin // RULE16
                    if (st_reg.det_st[i] == DET_COUNT) begin
                        st_next.det_rate[i] = classify(st_reg.det_cnt[i]); // RULE15
                        st_next.det_ok[i]   = 1'b1;
                    end
                    st_next.det_cnt[i] = 14'h0001;
                    st_next.det_st[i]  = DET_COUNT;
                end else begin
                    case (st_reg.det_st[i])
                        DET_COUNT: begin
                            if (st_reg.det_cnt[i] != 14'h3fff) begin
                                st_next.det_cnt[i] = st_reg.det_cnt[i] + 14'h0001;
                            end else begin
                                st_next.det_ok[i] = 1'b0; // no pulse: lost frame
                                st_next.det_st[i] = DET_WAIT;
                            end
                        end
                        default: st_next.det_st[i] = DET_WAIT;
                    endcase
                end
            end
        end

        // apb: read data captured in setup, writes on the access edge
        if (req.sel && !req.enable) begin
            st_next.prdata = 32'h0000_0000;
            if (req.addr == `OFF_CLK_CTRL) begin
                st_next.prdata[5:0] = st_reg.clk_ctrl;
            end else if (req.addr == `OFF_STATUS) begin
                st_next.prdata[`ST_SEL_LO+:2]    = st_reg.sel_s2;
                st_next.prdata[`ST_DET1_LO+:2]   = st_reg.det_rate[0];
                st_next.prdata[`ST_DET2_LO+:2]   = st_reg.det_rate[1];
                st_next.prdata[`ST_DET_OK_LO+:2] = st_reg.det_ok;
            end else if (grp_hit) begin
                // fields sit at their register positions; bit 3 reads zero
                st_next.prdata[`GC_IN_RATE_LO+:2]  = st_reg.cfg_pend[gidx[4:0]].in_rate;
                st_next.prdata[`GC_IN_INV]         = st_reg.cfg_pend[gidx[4:0]].in_inv;
                st_next.prdata[`GC_OUT_RATE_LO+:2] = st_reg.cfg_pend[gidx[4:0]].out_rate;
                st_next.prdata[`GC_OUT_INV]        = st_reg.cfg_pend[gidx[4:0]].out_inv;
            end
        end
        if (req.sel && req.enable && req.write) begin
            if (req.addr == `OFF_CLK_CTRL) begin
                st_next.clk_ctrl = req.wdata[5:0];
            end else if (grp_hit) begin
                st_next.cfg_pend[gidx[4:0]].in_rate  = rate_e'(req.wdata[`GC_IN_RATE_LO+:2]);
                st_next.cfg_pend[gidx[4:0]].in_inv   = req.wdata[`GC_IN_INV];
                st_next.cfg_pend[gidx[4:0]].out_rate = rate_e'(req.wdata[`GC_OUT_RATE_LO+:2]);
                st_next.cfg_pend[gidx[4:0]].out_inv  = req.wdata[`GC_OUT_INV];
            end
        end
    end

    // ----------------------------------------------------------------
    // state register; ce low freezes everything
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_reg        <= '0;
            st_reg.det_st <= '{DET_WAIT, DET_WAIT};
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // output enables follow the active rate; unused streams never drive
    always_comb begin
        for (int g = 0; g < NG; g++) begin
            for (int k = 0; k < 4; k++) begin
                SERIAL_OUT_OE_N[g][k] = !stream_used(st_reg.cfg_act[g].out_rate, k); // RULE7
            end
            SERIAL_OUT_FIRST_STREAMS[g]  = st_reg.tx_bit[g][0];
            SERIAL_OUT_SECOND_STREAMS[g] = st_reg.tx_bit[g][1];
            SERIAL_OUT_THIRD_STREAMS[g]  = st_reg.tx_bit[g][2];
            SERIAL_OUT_FOURTH_STREAMS[g] = st_reg.tx_bit[g][3];
        end
    end

    assign PRDATA           = st_reg.prdata;
    assign RX_DATA          = st_reg.rx_data;
    assign RX_VALID         = st_reg.rx_valid;
    assign TX_TAKEN         = st_reg.tx_taken;
    assign FRAME_EDGE_COUNT = st_reg.edge_cnt;
    assign FRAME_START      = st_reg.frame;

endmodule // tdm_stream_group_timing

/* testbench/tdm_group_timing_properties.sv */
// assertion checker for the tdm stream group timing block
`timescale 1ns/1ps

module tdm_group_timing_properties
    import tdm_timing_pkg::*;
#(
    parameter int NG = 32
) (
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RST,
    // apb
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic [11:0]        PADDR,
    input  wire logic               PREADY,
    input  wire logic               PSLVERR,
    // streams and framing
    input  wire logic [NG-1:0]      SERIAL_OUT_SECOND_STREAMS,
    input  wire logic [NG-1:0][3:0] SERIAL_OUT_OE_N,
    input  wire logic [NG-1:0][3:0] RX_VALID,
    input  wire logic [15:0]        FRAME_EDGE_COUNT,
    input  wire logic               FRAME_START
);
    // decode kept apart so the error check reads plainly
    logic mapped;
    assign mapped = PADDR == 12'h000 || PADDR == 12'h004 ||
                    (PADDR[11:8] == 4'h1 && PADDR[1:0] == 2'b00 && 32'(PADDR[7:2]) < NG);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence

    a_ready_now: assert property (s_access |-> PREADY)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (s_access |-> PSLVERR == !mapped)
        else $error("pslverr does not match the address decode");
    a_err_only_access: assert property (PSLVERR |-> s_access)
        else $error("pslverr outside an access phase");
    a_first_driven: assert property (SERIAL_OUT_OE_N[0][0] == 1'b0)
        else $error("first output stream tristated");
    a_oe_pattern: assert property (SERIAL_OUT_OE_N[0] inside {4'b0000, 4'b1100, 4'b1110})
        else $error("illegal tristate pattern");
    a_tristate_quiet: assert property (SERIAL_OUT_OE_N[0][1] [*2] |-> !SERIAL_OUT_SECOND_STREAMS[0])
        else $error("tristated second stream carries data");
    a_oe_at_frame: assert property ($changed(SERIAL_OUT_OE_N) |-> FRAME_START || $past(FRAME_START))
        else $error("tristate pattern changed away from a frame edge");
    a_start_single: assert property ($rose(FRAME_START) |-> s_pulse(FRAME_START))
        else $error("frame start longer than one cycle");
    a_count_at_start: assert property (FRAME_START |-> FRAME_EDGE_COUNT == 16'h0)
        else $error("edge count not cleared at frame start");
    a_count_step: assert property ($changed(FRAME_EDGE_COUNT) |->
        FRAME_EDGE_COUNT == 16'h0 || FRAME_EDGE_COUNT == $past(FRAME_EDGE_COUNT) + 16'h1)
        else $error("edge count jumped");
    a_valid_spacing: assert property (RX_VALID[0][0] |=> !RX_VALID[0][0] [*2])
        else $error("receive strobe closer than a master edge");
endmodule // tdm_group_timing_properties

bind tdm_stream_group_timing tdm_group_timing_properties #(.NG(NG)) props_inst (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SERIAL_OUT_SECOND_STREAMS(SERIAL_OUT_SECOND_STREAMS),
    .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .RX_VALID(RX_VALID),
    .FRAME_EDGE_COUNT(FRAME_EDGE_COUNT), .FRAME_START(FRAME_START)
);

/* testbench/tdm_link_source_model.sv */
// partner model: free-running tdm clock with master and optional frame pulses
`timescale 1ns/1ps

module tdm_link_source_model
    import tdm_timing_pkg::*;
#(
    parameter int MF = 16,
    parameter int OF = 1024
) (
    // clock and frame pulses
    output logic lclk,
    output logic mfp,
    output logic ofp
);
    int n;

    // clock never stops; pulses launch on the falling edge so they span one rising edge
    initial begin
        lclk = 1'b0;
        mfp  = 1'b0;
        ofp  = 1'b0;
        n    = 0;
        #37;
        forever begin
            #80;
            lclk = 1'b1;
            #80;
            lclk = 1'b0;
            n++;
            mfp = (n % MF) == 0;
            ofp = (n % OF) == 0;
        end
    end
endmodule // tdm_link_source_model

/* testbench/tdm_stream_group_timing_tb_top.sv */
// self-checking bench for the tdm stream group timing block
`timescale 1ns/1ps

module tdm_stream_group_timing_tb_top
    import tdm_timing_pkg::*;
;
    localparam int NG = 2;

    logic               clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               lclk, mfp, ofp, fstart;
    logic [1:0]         fsel;
    logic [NG-1:0]      si, so0, so1, so2, so3;
    logic [NG-1:0][3:0] oe_n, rx_data, rx_valid, tx_data, tx_taken;
    logic [15:0]        fcount;
    int                 num_errors, checks_done, cyc = 0, nofp = 0;

    tdm_stream_group_timing #(.NG(NG)) tdm_stream_group_timing_inst (
        .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MASTER_BIT_CLOCK_IN(lclk), .MASTER_FRAME_PULSE_IN(mfp), .OPTIONAL_BIT_CLOCKS_IN({lclk, lclk}),
        .OPTIONAL_FRAME_PULSES_IN({ofp, ofp}), .MASTER_FREQ_SELECT(fsel),
        .SERIAL_IN_FIRST_STREAMS(si), .SERIAL_IN_SECOND_STREAMS(si), .SERIAL_IN_THIRD_STREAMS(si),
        .SERIAL_IN_FOURTH_STREAMS(si), .SERIAL_OUT_FIRST_STREAMS(so0), .SERIAL_OUT_SECOND_STREAMS(so1),
        .SERIAL_OUT_THIRD_STREAMS(so2), .SERIAL_OUT_FOURTH_STREAMS(so3), .SERIAL_OUT_OE_N(oe_n),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data), .TX_TAKEN(tx_taken),
        .FRAME_EDGE_COUNT(fcount), .FRAME_START(fstart)
    );
    tdm_link_source_model tdm_link_source_model_inst (.lclk(lclk), .mfp(mfp), .ofp(ofp));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // setup, then access until pready; one idle edge so calls can follow directly
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic frames(input int n);
        repeat (n) @(posedge clk iff fstart === 1'b1);
    endtask

    // strobes seen over exactly one frame of the master timing
    task automatic one_frame(output int nv, output int nt, output logic [3:0] v, output logic [3:0] t);
        {nv, nt, v, t} = '0;
        frames(1);
        do begin
            nv += int'(rx_valid[0][0] === 1'b1);
            nt += int'(tx_taken[0][0] === 1'b1);
            v |= rx_valid[0];
            t |= tx_taken[0];
            @(posedge clk);
        end while (fstart !== 1'b1);
    endtask

    function automatic logic [3:0] exp_oe(input int r);
        return (r == 3) ? 4'b1110 : (r == 2) ? 4'b1100 : 4'b0000;
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, 12'h000, '0);
        check("clock control reset", rd, 32'h0);
        apb(1'b0, 12'h100, '0);
        check("group reset", rd, 32'h0);
        apb(1'b1, 12'h104, 32'hffffffff);
        apb(1'b0, 12'h104, '0);
        check("group readback", rd, 32'h77);
        apb(1'b1, 12'h104, 32'h0);
        apb(1'b0, 12'h108, '0);
        check("unmapped read", {rd[30:0], err}, 32'h1);
        $display("done registers");
    endtask

    task automatic t_select();
        int nv, nt;
        logic [3:0] v, t;
        for (int s = 0; s < 4; s++) begin
            fsel <= 2'(s);
            frames(2);
            apb(1'b0, 12'h004, '0);
            check("select status", {30'h0, rd[1:0]}, 32'(s));
            one_frame(nv, nt, v, t);
            check("input bits per frame", 32'(nv), 32'(16 >> s));
            check("output bits per frame", 32'(nt), 32'(16 >> s));
        end
        $display("done frequency select");
    endtask

    // the strobe lands a few cycles after the active edge, well inside a half period
    task automatic t_edge();
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, 12'h000, 32'(e));
            frames(2);
            @(posedge clk iff rx_valid[0][0] === 1'b1);
            check("link clock level at sample", {31'h0, lclk}, {31'h0, e == 0});
        end
        $display("done active edge");
    endtask

    task automatic t_level();
        int n;
        n = 0;
        apb(1'b1, 12'h000, 32'h2);
        frames(1);
        repeat (320) begin
            @(posedge clk);
            n += int'(fstart === 1'b1);
        end
        check("frame starts at low level", {31'h0, n >= 5}, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        frames(2);
        $display("done frame pulse level");
    endtask

    task automatic t_streams();
        int nv, nt;
        logic [3:0] v, t, oe;
        logic inv;
        fsel <= 2'b11;
        oe = 4'h0;
        for (int r = 0; r < 4; r++) begin
            inv = r[0];
            frames(1);
            apb(1'b1, 12'h100, {25'h0, inv, 2'(r), 1'b0, inv, 2'(r)});
            check("tristate before frame edge", {28'h0, oe_n[0]}, {28'h0, oe});
            oe = exp_oe(r);
            frames(1);
            one_frame(nv, nt, v, t);
            check("tristate per rate", {28'h0, oe_n[0]}, {28'h0, oe});
            check("inputs in use", {28'h0, v}, {28'h0, ~oe});
            check("outputs in use", {28'h0, t}, {28'h0, ~oe});
            check("received bits", {28'h0, rx_data[0]}, {28'h0, {4{~inv}} & ~oe});
            check("sent bits", {28'h0, so3[0], so2[0], so1[0], so0[0]}, {28'h0, {4{~inv}} & ~oe});
        end
        apb(1'b1, 12'h100, 32'h0);
        $display("done group rates");
    endtask

    task automatic t_detect();
        while (nofp < 2) @(posedge clk);
        repeat (40) @(posedge clk);
        apb(1'b0, 12'h004, '0);
        check("detected rates", {26'h0, rd[7:2]}, 32'h30);
        $display("done clock detection");
    endtask

    // ----------------------------------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // cycle ceiling well above the detection wait of two optional frames
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            end_of_test();
        end
    end
    always @(posedge ofp) nofp++;

    initial begin
        {psel, penable, pwrite, paddr, pwdata, fsel, num_errors, checks_done} = '0;
        rst = 1'b1;
        ce = 1'b1;
        si = '1;
        tx_data = '1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_select();
        t_edge();
        t_level();
        t_streams();
        t_detect();
        end_of_test();
    end
endmodule // tdm_stream_group_timing_tb_top
